// file: design/slcfg_buf2.sv
// two-entry valid/ready buffer in the response data path
`timescale 1ns/10ps
module slcfg_buf2 #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   typedef struct packed {
      logic [1:0]   cnt;
      logic [W-1:0] e0;
      logic [W-1:0] e1;
   } slcfg_b2_t;

   slcfg_b2_t s_q, s_d;
   logic      push, pop;

   // full and empty come straight from the count
   assign in_ready  = (s_q.cnt != 2'h2);
   assign out_valid = (s_q.cnt != 2'h0);
   assign out_data  = s_q.e0;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_d  = s_q;
      push = in_valid && in_ready;
      pop  = out_ready && out_valid;
      case ({push, pop})
         2'b10: begin
            if (s_q.cnt == 2'h0) s_d.e0 = in_data;
            else s_d.e1 = in_data;
            s_d.cnt = s_q.cnt + 2'h1;
         end
         2'b01: begin
            s_d.e0  = s_q.e1;
            s_d.cnt = s_q.cnt - 2'h1;
         end
         2'b11: begin
            // push with one held: the new word moves up behind the pop
            s_d.e0 = (s_q.cnt == 2'h1) ? in_data : s_q.e1;
            s_d.e1 = in_data;
         end
         default: s_d = s_q;
      endcase
      if (!ce) s_d = s_q;
      if (srst) s_d = '0;
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end
endmodule

// file: design/slcfg_pkg.sv
// constants, types and helpers shared by the serial link settings block
package slcfg_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ  = 10_000_000;
   localparam int CLK_NS  = 100;                // clock period in ns
   localparam int WAIT_NS = 1_000_000;          // wait step, 1 ms in ns
   localparam int MS_CYC  = WAIT_NS / CLK_NS;   // cycles per wait step

   // ****************************************************************
   // register map and field layout
   // ****************************************************************
   localparam logic [7:0] OFS_CFG  = 8'h00;     // pending settings
   localparam logic [7:0] OFS_ACT  = 8'h04;     // settings in force
   localparam logic [7:0] OFS_TXD  = 8'h08;     // response byte
   localparam logic [7:0] OFS_RXD  = 8'h0C;     // received byte
   localparam logic [7:0] OFS_STAT = 8'h10;     // status, write 1 clears
   localparam int POS_PROTO = 0;
   localparam int POS_BAUD  = 1;
   localparam int POS_LEN   = 4;
   localparam int POS_STOP  = 5;
   localparam int POS_PAR   = 6;
   localparam int POS_UNIT  = 8;
   localparam int POS_WAIT  = 16;
   localparam int POS_RXV   = 8;                // valid flag in received word
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   // ****************************************************************
   // encodings, limits and defaults
   // ****************************************************************
   localparam logic       PROTO_VND = 1'b0;
   localparam logic       PROTO_MOD = 1'b1;
   localparam logic [1:0] PAR_NONE  = 2'h0;
   localparam logic [1:0] PAR_EVEN  = 2'h1;
   localparam logic [1:0] PAR_ODD   = 2'h2;
   localparam logic [2:0] MAX_BAUD  = 3'h6;
   localparam logic [6:0] MAX_UNIT  = 7'h63;
   localparam logic [6:0] MAX_WAIT  = 7'h63;

   typedef struct packed {
      logic       proto;
      logic [2:0] baud;
      logic       len8;
      logic       stop2;
      logic [1:0] par;
      logic [6:0] unit;
      logic [6:0] wait_ms;
   } slcfg_cfg_t;

   localparam slcfg_cfg_t CFG_DEF = '{proto: PROTO_VND, baud: 3'h3, len8: 1'b0,
      stop2: 1'b1, par: PAR_EVEN, unit: 7'h01, wait_ms: 7'h14};

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} slcfg_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_END} slcfg_rx_t;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // cycles per bit, rounded to nearest
   function automatic logic [15:0] bdiv(input int clk_hz, input logic [2:0] sel);
      int r;
      case (sel)
         3'h0:    r = 1200;
         3'h1:    r = 2400;
         3'h2:    r = 4800;
         3'h4:    r = 19200;
         3'h5:    r = 38400;
         3'h6:    r = 57600;
         default: r = 9600;
      endcase
      return 16'((clk_hz + r / 2) / r);
   endfunction

   // parity bit for the character, odd inverts
   function automatic logic par_of(input logic [7:0] d, input logic len8,
                                   input logic [1:0] par);
      logic x;
      x = ^(len8 ? d : {1'b0, d[6:0]});
      return (par == PAR_ODD) ? ~x : x;
   endfunction

   function automatic logic [31:0] cfg2w(input slcfg_cfg_t c);
      logic [31:0] w;
      w                = 32'h0;
      w[POS_PROTO]     = c.proto;
      w[POS_BAUD +: 3] = c.baud;
      w[POS_LEN]       = c.len8;
      w[POS_STOP]      = c.stop2;
      w[POS_PAR +: 2]  = c.par;
      w[POS_UNIT +: 7] = c.unit;
      w[POS_WAIT +: 7] = c.wait_ms;
      return w;
   endfunction

endpackage

// file: design/slcfg_rx.sv
// character receiver, samples each bit at its middle
`timescale 1ns/10ps
module slcfg_rx
   import slcfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        rxd,
   input  wire logic [15:0] div,
   input  wire logic        len8,
   input  wire logic [1:0]  par,
   output logic             done,
   output logic [7:0]       data,
   output logic             perr,
   output logic             ferr
);
   typedef struct packed {
      slcfg_rx_t   st;
      logic [15:0] cnt;
      logic [3:0]  bit_n;
      logic [7:0]  sh;
      logic        perr;
      logic        ferr;
      logic        done;
   } slcfg_rxs_t;

   slcfg_rxs_t s_q, s_d;
   logic       tick, half;

   assign done = s_q.done;
   assign data = s_q.sh;
   assign perr = s_q.perr;
   assign ferr = s_q.ferr;

   // ****************************************************************
   // receive sequence
   // ****************************************************************
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      tick     = (s_q.cnt == div - 16'h1);
      half     = (s_q.cnt == {1'b0, div[15:1]});
      s_d.cnt  = s_q.cnt + 16'h1;
      case (s_q.st)
         RX_IDLE: begin
            s_d.cnt = 16'h0;
            if (!rxd) s_d.st = RX_START;
         end
         RX_START: if (half) begin
            // a start bit gone by mid-bit was a glitch
            s_d.st    = rxd ? RX_IDLE : RX_DATA;
            s_d.cnt   = 16'h0;
            s_d.bit_n = 4'h0;
            s_d.sh    = 8'h00;
            s_d.perr  = 1'b0;
            s_d.ferr  = 1'b0;
         end
         RX_DATA: if (tick) begin
            s_d.cnt             = 16'h0;
            s_d.sh[s_q.bit_n[2:0]] = rxd;
            s_d.bit_n           = s_q.bit_n + 4'h1;
            if (s_q.bit_n == (len8 ? 4'h7 : 4'h6))
               s_d.st = (par == PAR_NONE) ? RX_STOP : RX_PAR;
         end
         RX_PAR: if (tick) begin
            s_d.cnt  = 16'h0;
            s_d.perr = (rxd != par_of(s_q.sh, len8, par));
            s_d.st   = RX_STOP;
         end
         RX_STOP: if (tick) begin
            s_d.cnt  = 16'h0;
            s_d.ferr = !rxd;
            s_d.st   = RX_END;
         end
         RX_END: if (half) begin
            // report at the end of the stop bit so the wait starts there
            s_d.done = 1'b1;
            s_d.st   = RX_IDLE;
         end
         default: s_d.st = RX_IDLE;
      endcase
      if (!ce) s_d = s_q;
      if (srst) s_d = '0;
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end
endmodule

// file: design/slcfg_top.sv
// serial link settings, response timing and AXI4-Lite register file
//
// How it works
// - new settings take effect only at reset
// - protocol vendor framed or Modbus, vendor default
// - length and stop bits only under vendor protocol
// - unit number 0 to 99, default 1
// - seven baud rates, default 9.6 kbps
// - seven or eight data bits, default seven
// - one or two stop bits, default two
// - none, even or odd parity, default even
// - reply wait 0 to 99 ms, default 20
`timescale 1ns/10ps
module slcfg_top
   import slcfg_pkg::*;
#(
   parameter int CLK_FREQ  = CLK_HZ,
   parameter int MS_CYCLES = MS_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        fact_rst,
   input  wire logic        ce,
   input  wire logic        rxd_pin,
   output logic             txd_pin,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      slcfg_cfg_t  pend;
      slcfg_cfg_t  act;
      logic [1:0]  rx_sy;
      logic        awr, wr, aw_have, w_have;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arr, rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rx_full, ovr, perr, ferr;
      logic [7:0]  rx_byte;
      slcfg_tx_t   tst;
      logic [15:0] tdiv;
      logic [3:0]  tbit;
      logic [7:0]  tsh;
      logic        tpar, txd;
      logic [15:0] ms_div;
      logic [6:0]  ms_cnt;
      logic        armed;
   } slcfg_st_t;

   slcfg_st_t   s, n;
   logic [15:0] div_w;
   logic        len8_e, stop2_e, gate;
   logic        rx_done, rx_perr, rx_ferr;
   logic [7:0]  rx_data;
   logic        b_in_valid, b_in_ready, b_out_valid, b_out_ready;
   logic [7:0]  b_in_data, b_out_data;
   logic [31:0] mw, rd, pw;
   logic        tx_tick;
   slcfg_cfg_t  nc;

   // ****************************************************************
   // settings in force
   // ****************************************************************
   // Modbus frames force eight bits and derive stop bits from parity
   assign len8_e  = (s.act.proto == PROTO_MOD) ? 1'b1 : s.act.len8;
   assign stop2_e = (s.act.proto == PROTO_MOD) ? (s.act.par == PAR_NONE)
                                               : s.act.stop2;
   assign div_w   = bdiv(CLK_FREQ, s.act.baud);
   // reply held back until the wait after the last command has run out
   assign gate    = !s.armed || (s.ms_cnt >= s.act.wait_ms);

   assign txd_pin       = s.txd;
   assign s_axi_awready = s.awr;
   assign s_axi_wready  = s.wr;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_arready = s.arr;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;

   // ****************************************************************
   // datapath pieces
   // ****************************************************************
   slcfg_rx u_rx (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .rxd  (s.rx_sy[1]),
      .div  (div_w),
      .len8 (len8_e),
      .par  (s.act.par),
      .done (rx_done),
      .data (rx_data),
      .perr (rx_perr),
      .ferr (rx_ferr)
   );

   // a stalled transmitter fills this, then holds the bus write off
   slcfg_buf2 #(.W(8)) u_buf (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .in_valid  (b_in_valid),
      .in_ready  (b_in_ready),
      .in_data   (b_in_data),
      .out_valid (b_out_valid),
      .out_ready (b_out_ready),
      .out_data  (b_out_data)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      n           = s;
      b_in_valid  = 1'b0;
      b_in_data   = s.wdata[7:0];
      b_out_ready = 1'b0;
      tx_tick     = (s.tdiv == div_w - 16'h1);
      nc          = s.pend;
      pw          = cfg2w(s.pend);
      for (int i = 0; i < 4; i++) begin
         mw[8*i +: 8] = s.wstrb[i] ? s.wdata[8*i +: 8] : pw[8*i +: 8];
      end
      n.rx_sy = {s.rx_sy[0], rxd_pin};

      // write channel, address and data taken in either order
      if (s.awr && s_axi_awvalid) begin
         n.aw_have = 1'b1;
         n.awaddr  = s_axi_awaddr;
      end
      if (s.wr && s_axi_wvalid) begin
         n.w_have = 1'b1;
         n.wdata  = s_axi_wdata;
         n.wstrb  = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
      if (s.aw_have && s.w_have && !s.bvalid && (s.awaddr != OFS_TXD || b_in_ready)) begin
         n.aw_have = 1'b0;
         n.w_have  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = RESP_OK;
         case (s.awaddr)
            OFS_CFG: begin
               // out-of-range values are dropped, the field keeps its value
               nc.proto = mw[POS_PROTO];
               nc.len8  = mw[POS_LEN];
               nc.stop2 = mw[POS_STOP];
               if (mw[POS_BAUD +: 3] <= MAX_BAUD) nc.baud = mw[POS_BAUD +: 3];
               if (mw[POS_PAR +: 2] != 2'h3) nc.par = mw[POS_PAR +: 2];
               if (mw[POS_UNIT +: 7] <= MAX_UNIT) nc.unit = mw[POS_UNIT +: 7];
               if (mw[POS_WAIT +: 7] <= MAX_WAIT) nc.wait_ms = mw[POS_WAIT +: 7];
               n.pend = nc;
            end
            OFS_TXD: b_in_valid = s.wstrb[0];
            OFS_STAT: begin
               if (s.wdata[2]) n.ovr = 1'b0;
               if (s.wdata[1]) n.perr = 1'b0;
               if (s.wdata[0]) n.ferr = 1'b0;
            end
            OFS_ACT, OFS_RXD: n.bresp = RESP_OK;
            default: n.bresp = RESP_ERR;
         endcase
      end

      // read channel, one read in flight
      if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
      if (s.arr && s_axi_arvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OK;
         case (s_axi_araddr)
            OFS_CFG:  rd = cfg2w(s.pend);
            OFS_ACT:  rd = cfg2w(s.act);
            OFS_RXD:  rd = {23'h0, s.rx_full, s.rx_byte};
            OFS_STAT: rd = {25'h0, s.armed, s.tst != TX_IDLE, !b_in_ready,
                            s.rx_full, s.ovr, s.perr, s.ferr};
            default: begin
               rd      = 32'h0;
               n.rresp = RESP_ERR;
            end
         endcase
         n.rdata = rd;
         if (s_axi_araddr == OFS_RXD) n.rx_full = 1'b0;
      end else begin
         rd = 32'h0;
      end

      // received characters, a new one wins over a clear in the same cycle
      if (rx_done) begin
         n.rx_byte = rx_data;
         n.rx_full = 1'b1;
         if (s.rx_full && !(s.arr && s_axi_arvalid && s_axi_araddr == OFS_RXD))
            n.ovr = 1'b1;
         if (rx_perr) n.perr = 1'b1;
         if (rx_ferr) n.ferr = 1'b1;
      end

      // reply wait timer in 1 ms steps, restarted by every character
      if (rx_done) begin
         n.ms_div = 16'h0;
         n.ms_cnt = 7'h0;
         n.armed  = 1'b1;
      end else if (s.ms_cnt != 7'h7F) begin
         n.ms_div = s.ms_div + 16'h1;
         if (s.ms_div == 16'(MS_CYCLES - 1)) begin
            n.ms_div = 16'h0;
            n.ms_cnt = s.ms_cnt + 7'h1;
         end
      end

      // transmitter, one bit per div_w cycles
      n.tdiv = tx_tick ? 16'h0 : s.tdiv + 16'h1;
      case (s.tst)
         TX_IDLE: begin
            n.tdiv = 16'h0;
            if (b_out_valid && gate) begin
               b_out_ready = 1'b1;
               n.tsh       = b_out_data;
               n.tpar      = par_of(b_out_data, len8_e, s.act.par);
               n.txd       = 1'b0;
               n.tst       = TX_START;
               n.armed     = 1'b0;
            end
         end
         TX_START: if (tx_tick) begin
            n.tst  = TX_DATA;
            n.tbit = 4'h0;
            n.txd  = s.tsh[0];
         end
         TX_DATA: if (tx_tick) begin
            if (s.tbit == (len8_e ? 4'h7 : 4'h6)) begin
               n.tst  = (s.act.par == PAR_NONE) ? TX_STOP : TX_PAR;
               n.txd  = (s.act.par == PAR_NONE) ? 1'b1 : s.tpar;
               n.tbit = 4'h0;
            end else begin
               n.tbit = s.tbit + 4'h1;
               n.tsh  = {1'b0, s.tsh[7:1]};
               n.txd  = s.tsh[1];
            end
         end
         TX_PAR: if (tx_tick) begin
            n.tst = TX_STOP;
            n.txd = 1'b1;
         end
         TX_STOP: if (tx_tick) begin
            if (stop2_e && s.tbit == 4'h0) n.tbit = 4'h1;
            else n.tst = TX_IDLE;
         end
         default: n.tst = TX_IDLE;
      endcase

      // bus readies drop while a transfer waits to finish
      n.awr = !n.aw_have && !n.bvalid;
      n.wr  = !n.w_have && !n.bvalid;
      n.arr = !n.rvalid;
      if (!ce) n = s;

      // settings written before srst come into force here, fact_rst loads the defaults instead
      if (srst || fact_rst) begin
         n         = '0;
         n.rx_sy   = 2'h3;
         n.txd     = 1'b1;
         n.awr     = 1'b1;
         n.wr      = 1'b1;
         n.arr     = 1'b1;
         n.tst     = TX_IDLE;
         n.pend    = fact_rst ? CFG_DEF : s.pend;
         n.act     = fact_rst ? CFG_DEF : s.pend;
      end
   end

   always_ff @(posedge clk) begin
      s <= n;
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst || fact_rst);

   sequence rx_end_s;
      ce && rx_done;
   endsequence
   sequence tx_begin_s;
      $past(s.tst) == TX_IDLE && s.tst == TX_START;
   endsequence

   apply_at_reset_a: assert property (
      !$past(srst) && !$past(fact_rst) |-> $stable(s.act))
      else $error("settings changed outside reset");
   proto_default_a: assert property (
      $past(fact_rst) |-> s.act.proto == PROTO_VND && s.pend.stop2 && !s.pend.len8)
      else $error("factory defaults not loaded");
   modbus_format_a: assert property (
      s.act.proto == PROTO_MOD |-> len8_e && (stop2_e == (s.act.par == PAR_NONE)))
      else $error("modbus framing not forced");
   unit_range_a: assert property (
      s.pend.unit <= MAX_UNIT && s.act.unit <= MAX_UNIT)
      else $error("unit number out of range");
   bit_time_a: assert property (
      s.tst != TX_IDLE |-> s.tdiv < div_w && s.act.baud <= MAX_BAUD)
      else $error("bit timer overran");
   data_len_a: assert property (
      $past(s.tst) == TX_DATA && s.tst != TX_DATA |-> $past(s.tbit) == (len8_e ? 4'h7 : 4'h6))
      else $error("wrong data bit count");
   stop_count_a: assert property (
      $past(s.tst) == TX_STOP && s.tst == TX_IDLE |-> $past(s.tbit) == {3'h0, stop2_e})
      else $error("wrong stop bit count");
   parity_bit_a: assert property (
      tx_begin_s |-> s.tpar == par_of(s.tsh, len8_e, s.act.par) ##1
      (s.tst != TX_PAR || s.act.par != PAR_NONE))
      else $error("parity bit wrong");
   reply_wait_a: assert property (
      tx_begin_s |-> !$past(s.armed) || $past(s.ms_cnt) >= $past(s.act.wait_ms))
      else $error("reply sent before wait ran out");
   wait_restart_a: assert property (
      rx_end_s |=> s.armed && s.ms_cnt == 7'h0 && s.ms_div == 16'h0)
      else $error("wait not restarted by character");
endmodule

// file: testbench/slcfg_host.sv
// host computer model on the far side of the serial line
`timescale 1ns/10ps
module slcfg_host
   import slcfg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       txd,
   output logic            rxd,
   input  wire logic [7:0] bit_cyc,
   input  wire logic       len8,
   input  wire logic [1:0] par,
   input  wire logic       stop2
);
   // ***************************
   // line model
   // ***************************
   int         cyc = 0;
   int         end_cyc = 0;
   int         bad_frames = 0;
   logic [7:0] rx_q[$];

   // free count, used to time the reply gap
   always @(posedge clk) cyc <= cyc + 1;
   initial rxd = 1'b1;

   // send one character with the same framing as the device
   task automatic send(input logic [7:0] d);
      int i;
      @(posedge clk);
      rxd <= 1'b0;
      repeat (bit_cyc) @(posedge clk);
      for (i = 0; i < (len8 ? 8 : 7); i++) begin
         rxd <= d[i];
         repeat (bit_cyc) @(posedge clk);
      end
      if (par != PAR_NONE) begin
         rxd <= ^d[6:0] ^ (len8 & d[7]) ^ (par == PAR_ODD);
         repeat (bit_cyc) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (bit_cyc * (stop2 ? 2 : 1)) @(posedge clk);
      end_cyc = cyc;
   endtask

   // receive mid-bit; parity and every stop bit are judged, a slip counts
   initial begin : rx
      logic [7:0] d;
      logic       p;
      int         i;
      forever begin
         wait (txd === 1'b1);
         @(negedge txd);
         repeat (bit_cyc / 2) @(posedge clk);
         d = 8'h00;
         p = (par == PAR_ODD);
         for (i = 0; i < (len8 ? 8 : 7); i++) begin
            repeat (bit_cyc) @(posedge clk);
            d[i] = txd;
            p = p ^ txd;
         end
         if (par != PAR_NONE) begin
            repeat (bit_cyc) @(posedge clk);
            if (txd !== p) bad_frames++;
         end
         for (i = 0; i < (stop2 ? 2 : 1); i++) begin
            repeat (bit_cyc) @(posedge clk);
            if (txd !== 1'b1) bad_frames++;
         end
         rx_q.push_back(d);
      end
   end
endmodule

// file: testbench/tb_serial_link_settings.sv
// self-checking bench for the serial link settings block
`timescale 1ns/10ps
module tb_serial_link_settings
   import slcfg_pkg::*;
;
   logic        clk = 1'b0, srst = 1'b1, fact_rst = 1'b1, ce = 1'b1, rxd_pin, txd_pin;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, bit_cyc = 8'h0C;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp, par = PAR_EVEN;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, len8 = 1'b0, stop2 = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          miscompares = 0;
   int          num_checks = 0;

   // short bit and wait times keep the run brief: 9.6k is 12 cycles, 1 ms is 20
   slcfg_top #(.CLK_FREQ(115200), .MS_CYCLES(20)) uut (.clk, .srst, .fact_rst, .ce,
      .rxd_pin, .txd_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   slcfg_host host (.clk, .txd(txd_pin), .rxd(rxd_pin), .bit_cyc, .len8, .par, .stop2);

   initial begin
      forever #50 clk = ~clk;
   end

   // ***************************
   // bus and compare tasks
   // ***************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            resp = s_axi_bresp;
            break;
         end
      end
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            break;
         end
      end
   endtask

   task automatic wait_rx(input int k);
      for (int n = 0; n < 3000 && host.rx_q.size() < k; n++) @(posedge clk);
   endtask

   task automatic results();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ***************************
   // scenarios
   // ***************************
   task automatic t_reset();
      axw(OFS_ACT, 32'h0);
      chk(resp, RESP_OK);
      axw(8'h14, 32'h0);
      chk(resp, RESP_ERR);
      axr(OFS_ACT);
      chk(rd, 32'h0014_0166);
      axr(8'h14);
      chk(resp, RESP_ERR);
      axr(8'h02);
      chk(resp, RESP_ERR);
      $display("test reset done");
   endtask

   // four bytes queued: the fourth must stall until the first has gone out
   task automatic t_tx();
      logic [7:0] eb[4] = '{8'h55, 8'h2A, 8'h7F, 8'h01};
      int         t0;
      foreach (eb[i]) if (i < 3) axw(OFS_TXD, {24'h0, eb[i]});
      axr(OFS_STAT);
      chk(rd[4], 1'b1);
      t0 = host.cyc;
      axw(OFS_TXD, 32'h81);
      chk(host.cyc - t0 > 60, 1'b1);
      wait_rx(4);
      foreach (eb[i]) chk(host.rx_q.pop_front(), eb[i]);
      chk(host.bad_frames, 0);
      $display("test tx done");
   endtask

   // every baud and parity code, out-of-range ones ignored, none in force yet
   task automatic t_cfg();
      logic [31:0] e;
      e = 32'h0014_0166;
      for (int i = 0; i < 8; i++) begin
         axw(OFS_CFG, (e & 32'hFFFF_FF30) | (i & 1) | (i << 1) | ((i & 3) << 6));
         e[0] = i[0];
         if (i < 7) e[3:1] = i[2:0];
         if ((i & 3) < 3) e[7:6] = i[1:0];
         axr(OFS_CFG);
         chk(rd, e);
      end
      // Modbus with seven bits and one stop stored: the framing must override them
      axw(OFS_CFG, 32'h0002_6389);
      axw(OFS_CFG, 32'h0002_6489);
      axr(OFS_CFG);
      chk(rd, 32'h0002_6389);
      axr(OFS_ACT);
      chk(rd, 32'h0014_0166);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      axr(OFS_ACT);
      chk(rd, 32'h0002_6389);
      $display("test cfg done");
   endtask

   // Modbus, 19.2k, odd: 8 bits and one stop forced, 2 ms reply wait in force
   task automatic t_wait();
      int n;
      bit_cyc <= 8'h06;
      len8 <= 1'b1;
      par <= PAR_ODD;
      stop2 <= 1'b0;
      host.send(8'hA5);
      // software answers only once the command has reached the receiver
      repeat (bit_cyc) @(posedge clk);
      axw(OFS_TXD, 32'h3C);
      for (n = 0; n < 500 && txd_pin === 1'b1; n++) @(posedge clk);
      n = host.cyc - host.end_cyc;
      chk(n >= 40 && n <= 52, 1'b1);
      wait_rx(1);
      chk(host.rx_q.pop_front(), 8'h3C);
      axr(OFS_RXD);
      chk(rd, 32'h0000_01A5);
      axr(OFS_STAT);
      chk(rd[2:0], 3'h0);
      $display("test wait done");
   endtask

   // whole run is under 1000 cycles, so 20000 means a hang
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end

   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      fact_rst <= 1'b0;
      t_reset();
      t_tx();
      t_cfg();
      t_wait();
      results();
   end
endmodule
